//--- include/eewp_pkg.sv
// constants and types shared by the eeprom write host
// assumes a 20 MHz system clock; all pin timing is counted in its cycles
package eewp_pkg;
    // clock period and the pin timing it is measured against
    localparam int CLK_NS = 50;
    localparam int WE_LOW_NS = 110;
    localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int GLITCH_NS = 20;
    localparam int BLC_MAX_US = 100;
    localparam int BLC_WAIT_CYC = (BLC_MAX_US * 1000 + CLK_NS - 1) / CLK_NS + 1;
    localparam int INIT_MAX_MS = 10;
    localparam int INIT_CYC = INIT_MAX_MS * 1000000 / CLK_NS;
    localparam int PROG_MAX_MS = 5;
    localparam int PROG_CYC = PROG_MAX_MS * 1000000 / CLK_NS;
    // bus widths
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int CNT_W = 24;
    // default command pairs of the lock and unlock sequences, step 0 rightmost
    localparam logic [2:0][12:0] LOCK_ADDR_DEF = {13'h1555, 13'h0aaa, 13'h1555};
    localparam logic [2:0][7:0] LOCK_DATA_DEF = {8'ha0, 8'h55, 8'haa};
    localparam logic [5:0][12:0] UNLK_ADDR_DEF =
        {13'h1555, 13'h0aaa, 13'h1555, 13'h1555, 13'h0aaa, 13'h1555};
    localparam logic [5:0][7:0] UNLK_DATA_DEF = {8'h20, 8'h55, 8'haa, 8'h80, 8'h55, 8'haa};
    // last step index of each sequence
    localparam logic [2:0] LOCK_LAST = 3'h2;
    localparam logic [2:0] UNLK_LAST = 3'h5;
    localparam logic [2:0] GUARD_LAST = 3'h3;
    // user commands
    typedef enum logic [1:0] {OP_WRITE, OP_LOCK, OP_UNLOCK} eewp_op_t;
    // controller states
    typedef enum logic [2:0] {S_INIT, S_IDLE, S_SETUP, S_PULSE, S_GAP, S_BLC, S_PROG}
        eewp_state_t;
endpackage

//--- logic/eewp_host.sv
// host controller that writes a parallel eeprom and manages its software write lock
// assumes the ready/busy line has an external pull-up and supplyOk comes from a supply monitor
`timescale 1ns/1ps

// Functional notes
// RULE1: device pulls busy low while programming
// RULE2: busy pin is open drain, shared
// RULE3: no writes while supply below threshold
// RULE4: no writes during power-on delay
// RULE5: output select low or selects high inhibit
// RULE6: strobes under 20 ns start nothing
// RULE7: lock needs three command writes
// RULE8: lock commands use page-write byte timing
// RULE9: locked writes need the three-command preamble
// RULE10: lock state survives power cycles
// RULE11: device ships unlocked
// RULE12: six-write sequence clears the lock
// RULE13: after sixth unlock byte, writes are plain
// RULE14: lock set at its last command
// RULE15: data follows lock within byte-load window
// RULE16: byte-load timer expiry starts programming
// RULE17: write needs selects low, output select high
// RULE18: programming completes within five milliseconds
// RULE19: command addresses and data are parameters
// RULE20: locked unguarded write changes nothing
module eewp_host
    import eewp_pkg::*;
#(
    parameter int INIT_WAIT = INIT_CYC,
    parameter int PROG_WAIT = PROG_CYC,
    parameter logic [2:0][12:0] LOCK_ADDR = LOCK_ADDR_DEF,
    parameter logic [2:0][7:0] LOCK_DATA = LOCK_DATA_DEF,
    parameter logic [5:0][12:0] UNLK_ADDR = UNLK_ADDR_DEF,
    parameter logic [5:0][7:0] UNLK_DATA = UNLK_DATA_DEF,
    parameter logic LOCK_AT_RESET = 1'b0
)(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // user command side
    input wire logic cmdValid,
    output logic cmdReady,
    input wire eewp_op_t cmdOp,
    input wire logic [ADDR_W-1:0] cmdAddr,
    input wire logic [DATA_W-1:0] cmdData,
    output logic lockActive,
    output logic progBusy,
    output logic progTimeout,
    // eeprom pins
    output logic ceN,
    output logic oeN,
    output logic weN,
    output logic [ADDR_W-1:0] addrOut,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOeN,
    input wire logic rdyIn,
    input wire logic supplyOk
);
    // whole controller state in one record
    typedef struct packed {
        eewp_state_t st;
        logic [CNT_W-1:0] cnt;       // shared timer
        logic [2:0] step;            // index inside the command sequence
        eewp_op_t op;                // latched command
        logic lockOn;                // host copy of the device lock
        logic [ADDR_W-1:0] wAddr;    // latched user address
        logic [DATA_W-1:0] wData;    // latched user byte
        logic ceN;
        logic weN;
        logic dataOeN;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic busy;
        logic timeout;
        logic rdyMeta;               // first synchroniser stages
        logic rdySync;
        logic supMeta;
        logic supSync;
    } eewp_regs_t;

    eewp_regs_t r_r;
    eewp_regs_t r_nxt;
    logic [2:0] lastStep;            // final step of the running sequence
    logic [ADDR_W-1:0] stepAddr;     // address of the running step
    logic [DATA_W-1:0] stepData;     // data of the running step

    // sequence table lookup; guarded writes reuse the lock preamble then the user byte
    always_comb
    begin
        lastStep = 3'h0;
        stepAddr = r_r.wAddr;
        stepData = r_r.wData;
        case (r_r.op)
            OP_LOCK:
            begin
                lastStep = LOCK_LAST; // RULE7
                stepAddr = LOCK_ADDR[r_r.step[1:0]]; // RULE19
                stepData = LOCK_DATA[r_r.step[1:0]];
            end
            OP_UNLOCK:
            begin
                lastStep = UNLK_LAST; // RULE12
                stepAddr = UNLK_ADDR[r_r.step];
                stepData = UNLK_DATA[r_r.step];
            end
            default:
            begin
                // locked device accepts data only right after the preamble
                if (r_r.lockOn && r_r.step != GUARD_LAST) // RULE9
                begin
                    stepAddr = LOCK_ADDR[r_r.step[1:0]];
                    stepData = LOCK_DATA[r_r.step[1:0]];
                end
                lastStep = r_r.lockOn ? GUARD_LAST : 3'h0; // RULE20
            end
        endcase
    end

    // next-state logic
    always_comb
    begin
        r_nxt = r_r;
        r_nxt.rdyMeta = rdyIn; // RULE2
        r_nxt.rdySync = r_r.rdyMeta;
        r_nxt.supMeta = supplyOk;
        r_nxt.supSync = r_r.supMeta;
        // one shared down-counter; states that need a fresh count reload it
        if (r_r.cnt != '0)
        begin
            r_nxt.cnt = r_r.cnt - CNT_W'(1);
        end
        case (r_r.st)
            S_INIT:
            begin
                // supply loss below reloads the count, so zero means the full delay ran
                if (r_r.supSync && r_r.cnt == '0) // RULE4
                begin
                    r_nxt.st = S_IDLE;
                end
            end
            S_IDLE:
            begin
                if (cmdValid && cmdReady)
                begin
                    r_nxt.op = cmdOp;
                    r_nxt.wAddr = cmdAddr;
                    r_nxt.wData = cmdData;
                    r_nxt.step = 3'h0;
                    r_nxt.timeout = 1'b0;
                    r_nxt.st = S_SETUP;
                end
            end
            S_SETUP:
            begin
                // address and data move with the strobe fall; zero setup is enough
                r_nxt.addr = stepAddr; // RULE19
                r_nxt.data = stepData;
                r_nxt.ceN = 1'b0; // RULE17
                r_nxt.weN = 1'b0;
                r_nxt.dataOeN = 1'b0;
                r_nxt.cnt = CNT_W'(WE_LOW_CYC - 1);
                r_nxt.st = S_PULSE;
            end
            S_PULSE:
            begin
                // strobe stays low well past the glitch filter
                if (r_r.cnt == '0) // RULE6
                begin
                    r_nxt.weN = 1'b1;
                    r_nxt.st = S_GAP;
                    // last command of a lock or unlock sequence sets or clears the host copy
                    if (r_r.step == lastStep && (r_r.op == OP_LOCK || r_r.op == OP_UNLOCK))
                    begin
                        r_nxt.lockOn = (r_r.op == OP_LOCK); // RULE14 RULE13
                    end
                end
            end
            S_GAP:
            begin
                // short gap keeps every byte inside the byte-load window
                r_nxt.ceN = 1'b1; // RULE8
                r_nxt.dataOeN = 1'b1;
                if (r_r.step == lastStep)
                begin
                    r_nxt.cnt = CNT_W'(BLC_WAIT_CYC);
                    r_nxt.busy = 1'b1;
                    r_nxt.st = S_BLC;
                end
                else
                begin
                    r_nxt.step = r_r.step + 3'h1; // RULE15
                    r_nxt.st = S_SETUP;
                end
            end
            S_BLC:
            begin
                // strobe held high until the device timer expires
                if (r_r.cnt == '0) // RULE16
                begin
                    r_nxt.cnt = CNT_W'(PROG_WAIT);
                    r_nxt.st = S_PROG;
                end
            end
            S_PROG:
            begin
                // a released line means done or nothing programmed at all
                if (r_r.rdySync || r_r.cnt == '0) // RULE1 RULE18
                begin
                    r_nxt.busy = 1'b0;
                    r_nxt.timeout = !r_r.rdySync;
                    r_nxt.st = S_IDLE;
                end
            end
            default:
            begin
                r_nxt.st = S_INIT;
            end
        endcase
        // supply loss aborts any write and restarts the power-on wait
        if (!r_r.supSync) // RULE3
        begin
            r_nxt.st = S_INIT;
            r_nxt.ceN = 1'b1;
            r_nxt.weN = 1'b1;
            r_nxt.dataOeN = 1'b1;
            r_nxt.busy = 1'b0;
            r_nxt.cnt = CNT_W'(INIT_WAIT);
        end
    end

    // state register; lock copy starts from the strap since the device keeps it
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            r_r <= '0;
            r_r.st <= S_INIT;
            r_r.cnt <= CNT_W'(INIT_WAIT);
            r_r.ceN <= 1'b1;
            r_r.weN <= 1'b1;
            r_r.dataOeN <= 1'b1;
            r_r.lockOn <= LOCK_AT_RESET; // RULE10 RULE11
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    // outputs; output select never asserted so the device stays writable
    assign cmdReady = (r_r.st == S_IDLE) && r_r.supSync;
    assign oeN = 1'b1; // RULE5
    assign ceN = r_r.ceN;
    assign weN = r_r.weN;
    assign dataOeN = r_r.dataOeN;
    assign addrOut = r_r.addr;
    assign dataOut = r_r.data;
    assign lockActive = r_r.lockOn;
    assign progBusy = r_r.busy;
    assign progTimeout = r_r.timeout;

    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence lockLastPulse;
        r_r.st == S_PULSE && r_r.op == OP_LOCK && r_r.step == LOCK_LAST && r_r.cnt == '0;
    endsequence
    sequence unlockLastPulse;
        r_r.st == S_PULSE && r_r.op == OP_UNLOCK && r_r.step == UNLK_LAST && r_r.cnt == '0;
    endsequence
    sequence lockedWriteTaken;
        r_r.st == S_IDLE && cmdValid && cmdReady && cmdOp == OP_WRITE && r_r.lockOn;
    endsequence

    weLowWidth_a: assert property ($fell(weN) |-> !weN [*3] ##1 weN) // RULE6
        else $error("write strobe low width wrong");
    writeGate_a: assert property (!weN |-> !ceN && oeN && !dataOeN) // RULE17 RULE5
        else $error("write strobe without selects");
    lowSupply_a: assert property (!r_r.supSync |=> weN && ceN) // RULE3
        else $error("strobe active with supply low");
    initHold_a: assert property (r_r.st == S_INIT |-> !cmdReady && weN) // RULE4
        else $error("write accepted in power-on wait");
    lockSet_a: assert property (lockLastPulse |=> lockActive) // RULE14
        else $error("lock not set at last command");
    unlockClr_a: assert property (unlockLastPulse |=> !lockActive) // RULE12
        else $error("lock not cleared after unlock");
    guardFirst_a: assert property (lockedWriteTaken |=> ##1 addrOut == LOCK_ADDR[0] // RULE9
        && dataOut == LOCK_DATA[0] && !weN)
        else $error("locked write without preamble");
    byteGap_a: assert property ($rose(weN) |-> ##[1:3] // RULE8
        (!weN || r_r.st == S_BLC || r_r.st == S_INIT))
        else $error("byte gap too long");
    blcHold_a: assert property (r_r.st == S_BLC |-> weN && ceN) // RULE16
        else $error("strobe moved during byte-load wait");
    progDone_a: assert property (r_r.st == S_PROG && r_r.rdySync && r_r.supSync // RULE1
        |=> r_r.st == S_IDLE && !progBusy)
        else $error("ready line ignored");
endmodule

//--- test/eewp_dev_model.sv
// behavioural model of the parallel eeprom behind the write host
// assumes pins sampled on sys_clk and an external pull-up on the ready line
`timescale 1ns/1ps
module eewp_dev_model
    import eewp_pkg::*;
#(
    parameter int BLC_CYC = 1990,
    parameter int INIT_CYC_M = 15,
    parameter int PROG_FAST = 30,
    parameter int PROG_SLOW = 200
)(
    // clock
    input wire logic sys_clk,
    // device pins
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic [ADDR_W-1:0] addrIn,
    input wire logic [DATA_W-1:0] dataIn,
    input wire logic supplyOk,
    output logic rdyOeN,
    // bench controls and views
    input wire logic slowProg,
    output logic locked,
    output int strobeCnt
);
    logic [DATA_W-1:0] mem [0:8191];
    logic [ADDR_W-1:0] qa[$];
    logic [DATA_W-1:0] qd[$];
    logic [ADDR_W-1:0] la;
    logic [DATA_W-1:0] ld;
    logic wasWr, isL, isU;
    int blc, initCnt, progCnt, k;
    // array erased, lock off from the factory
    initial
    begin
        for (k = 0; k < 8192; k++) mem[k] = 8'hff;
        locked = 1'b0;
        rdyOeN = 1'b1;
        strobeCnt = 0;
        wasWr = 1'b0;
        blc = 0;
        initCnt = 0;
        progCnt = 0;
    end
    // one step per clock: inhibit, byte load, timer, programming
    always @(posedge sys_clk)
    begin
        if (!supplyOk)
        begin
            initCnt = 0;
            qa.delete();
            qd.delete();
        end
        else if (initCnt < INIT_CYC_M) initCnt++;
        if (wasWr && weN && supplyOk && initCnt >= INIT_CYC_M)
        begin
            qa.push_back(la);
            qd.push_back(ld);
            strobeCnt++;
            blc = 1;
        end
        else if (blc > 0 && ++blc >= BLC_CYC)
        begin
            isL = qa.size() >= 3;
            isU = qa.size() >= 6;
            for (k = 0; k < 6; k++)
            begin
                if (k < 3 && isL) isL = qa[k] == LOCK_ADDR_DEF[k] && qd[k] == LOCK_DATA_DEF[k];
                if (isU) isU = qa[k] == UNLK_ADDR_DEF[k] && qd[k] == UNLK_DATA_DEF[k];
            end
            k = isU ? 6 : (isL ? 3 : 0);
            if (isU) locked = 1'b0;
            else if (isL) locked = 1'b1;
            // a locked write without the preamble is dropped silently
            if ((!locked || isL || isU) && k < qa.size())
            begin
                for (; k < qa.size(); k++) mem[qa[k]] = qd[k];
                progCnt = slowProg ? PROG_SLOW : PROG_FAST;
            end
            qa.delete();
            qd.delete();
            blc = 0;
        end
        wasWr = !ceN && !weN && oeN;
        if (wasWr) blc = 0;
        la = addrIn;
        ld = dataIn;
        rdyOeN = !(progCnt > 0);
        if (progCnt > 0) progCnt--;
    end
endmodule

//--- test/testbench.sv
// self-checking bench for the eeprom write host against the device model
// assumes short power-on and programming waits set through parameters
`timescale 1ns/1ps
module testbench;
    import eewp_pkg::*;
    logic sys_clk, nrst, cmdValid, supplyOk, slowProg, rdyOeN, locked;
    logic cmdReady, lockActive, progBusy, progTimeout, ceN, oeN, weN, dataOeN, sawBusy, sawProg;
    eewp_op_t cmdOp;
    logic [ADDR_W-1:0] cmdAddr, addrOut;
    logic [DATA_W-1:0] cmdData, dataOut;
    int strobeCnt, err_total, check_count, s0, i;
    // pull-up on the ready line; a released data bus shows the inverted data
    wire rdyIn = rdyOeN ? 1'b1 : 1'b0;
    wire [DATA_W-1:0] busData = dataOeN ? ~dataOut : dataOut;
    eewp_host #(.INIT_WAIT(20), .PROG_WAIT(50)) eewp_host_inst (.sys_clk(sys_clk),
        .nrst(nrst), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
        .cmdAddr(cmdAddr), .cmdData(cmdData), .lockActive(lockActive), .progBusy(progBusy),
        .progTimeout(progTimeout), .ceN(ceN), .oeN(oeN), .weN(weN), .addrOut(addrOut),
        .dataOut(dataOut), .dataOeN(dataOeN), .rdyIn(rdyIn), .supplyOk(supplyOk));
    eewp_dev_model eewp_dev_model_inst (.sys_clk(sys_clk), .ceN(ceN), .oeN(oeN), .weN(weN),
        .addrIn(addrOut), .dataIn(busData), .supplyOk(supplyOk), .rdyOeN(rdyOeN),
        .slowProg(slowProg), .locked(locked), .strobeCnt(strobeCnt));
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // bounded wait for the host to return to idle, noting busy on the way
    task wait_ready(input int lim);
        for (i = 0; i < lim && cmdReady !== 1'b1; i++)
        begin
            @(negedge sys_clk);
            if (rdyIn === 1'b0) sawBusy = 1'b1;
            if (progBusy === 1'b1) sawProg = 1'b1;
        end
        if (i >= lim) check("ready wait", 0, 1);
        if (i >= lim) complete_run;
    endtask
    task run_cmd(input eewp_op_t op, input logic [12:0] a, input logic [7:0] d);
        s0 = strobeCnt;
        sawBusy = 1'b0;
        sawProg = 1'b0;
        cmdOp = op;
        cmdAddr = a;
        cmdData = d;
        cmdValid = 1'b1;
        wait_ready(50);
        @(negedge sys_clk);
        cmdValid = 1'b0;
        @(negedge sys_clk);
        wait_ready(6000);
    endtask
    // reset the host and count the power-on wait
    task t_reset;
        nrst = 1'b0;
        repeat (12) @(negedge sys_clk);
        check("pins idle", {ceN, weN, dataOeN, oeN, cmdReady}, 5'h1e);
        nrst = 1'b1;
        wait_ready(200);
        check("init wait", i >= 20, 1);
        $display("reset test done");
    endtask
    task t_write(input logic [12:0] a, input logic [7:0] d, input int n, input bit lands);
        run_cmd(OP_WRITE, a, d);
        check("strobes", strobeCnt - s0, n);
        check("busy seen", sawBusy, lands);
        check("host busy", sawProg, 1);
        check("busy clear", progBusy, 0);
        check("array", eewp_dev_model_inst.mem[a], lands ? d : 8'hff);
        check("timeout", progTimeout, 0);
        $display("write test done");
    endtask
    task t_lock(input eewp_op_t op, input int n, input logic exp);
        run_cmd(op, 13'h0000, 8'h00);
        check("cmd strobes", strobeCnt - s0, n);
        check("device lock", locked, exp);
        check("host lock", lockActive, exp);
        $display("lock test done");
    endtask
    // power cycle keeps the device lock; host copy comes back clear
    task t_power;
        supplyOk = 1'b0;
        repeat (3) @(negedge sys_clk);
        check("no take", cmdReady, 0);
        check("pins off", {ceN, weN}, 2'h3);
        supplyOk = 1'b1;
        t_reset();
        check("lock kept", locked, 1);
        check("host copy", lockActive, 0);
        $display("power test done");
    endtask
    task t_slow;
        slowProg = 1'b1;
        run_cmd(OP_WRITE, 13'h0044, 8'h3c);
        check("slow timeout", progTimeout, 1);
        slowProg = 1'b0;
        repeat (250) @(negedge sys_clk);
        $display("slow test done");
    endtask
    initial
    begin
        {nrst, cmdValid, slowProg, cmdAddr, cmdData} = '0;
        supplyOk = 1'b1;
        cmdOp = OP_WRITE;
        err_total = 0;
        check_count = 0;
        @(negedge sys_clk);
        t_reset();
        check("ships clear", {locked, lockActive}, 0);
        t_write(13'h0123, 8'h5a, 1, 1'b1);
        t_lock(OP_LOCK, 3, 1'b1);
        t_write(13'h1f00, 8'hc3, 4, 1'b1);
        t_power();
        t_write(13'h0200, 8'h77, 1, 1'b0);
        t_lock(OP_UNLOCK, 6, 1'b0);
        t_write(13'h0201, 8'h81, 1, 1'b1);
        t_slow();
        complete_run;
    end
endmodule
